// File: pkg/operand_decode_pkg.sv
/*
 * Shared types and constants for the operand format decoder: field positions,
 * format codes, operand meanings and the structs carried on its two ports.
 * Assumes an upstream opcode decoder names the format and the row within it.
 */
package operand_decode_pkg;

    // ****************************************************************
    // Field layout
    // ****************************************************************
    localparam int WORD_W = 16;
    localparam int REG_W = 4;
    localparam int DISP_W = 12;
    localparam int IMM_W = 8;
    localparam int VAR_W = 3;
    localparam int HI_NIB_LSB = 8;
    localparam int MID_NIB_LSB = 4;
    localparam int LO_NIB_LSB = 0;
    localparam int BYTE_LSB = 0;
    localparam int D12_LSB = 0;
    localparam logic [REG_W-1:0] REG_ZERO = 4'h0;
    localparam logic [3:0] DISP_BITS_NONE = 4'h0;
    localparam logic [3:0] DISP_BITS_4 = 4'h4;
    localparam logic [3:0] DISP_BITS_8 = 4'h8;
    localparam logic [3:0] DISP_BITS_12 = 4'hC;
    localparam logic [1:0] RST_SYNC_CLEAR = 2'h0;

    // ****************************************************************
    // Row selectors within a format
    // ****************************************************************
    localparam logic [VAR_W-1:0] ROW_0 = 3'h0;
    localparam logic [VAR_W-1:0] ROW_1 = 3'h1;
    localparam logic [VAR_W-1:0] ROW_2 = 3'h2;
    localparam logic [VAR_W-1:0] ROW_3 = 3'h3;
    localparam logic [VAR_W-1:0] ROW_4 = 3'h4;
    localparam logic [VAR_W-1:0] ROW_5 = 3'h5;

    // ****************************************************************
    // Enumerations
    // ****************************************************************
    typedef enum logic [3:0] {
        FMT_ZERO = 4'h0,
        FMT_N = 4'h1,
        FMT_M = 4'h2,
        FMT_NM = 4'h3,
        FMT_MD = 4'h4,
        FMT_ND4 = 4'h5,
        FMT_NMD = 4'h6,
        FMT_D = 4'h7,
        FMT_D12 = 4'h8,
        FMT_ND8 = 4'h9,
        FMT_I = 4'hA,
        FMT_NI = 4'hB
    } format_e;

    typedef enum logic [3:0] {
        OPD_NONE = 4'h0,
        OPD_DIRECT = 4'h1,
        OPD_INDIRECT = 4'h2,
        OPD_POST_INC = 4'h3,
        OPD_PRE_DEC = 4'h4,
        OPD_INDEXED_ZERO = 4'h5,
        OPD_REG_DISP = 4'h6,
        OPD_GBASE_DISP = 4'h7,
        OPD_PC_DISP = 4'h8,
        OPD_PC_REL = 4'h9,
        OPD_PC_REL_REG = 4'hA,
        OPD_IMMEDIATE = 4'hB,
        OPD_CTRL_SYS = 4'hC,
        OPD_ACCUM = 4'hD,
        OPD_GBASE_INDEXED = 4'hE,
        OPD_TRAP = 4'hF
    } operand_e;

    // ****************************************************************
    // Port carriers
    // ****************************************************************
    typedef struct packed {
        logic valid;
        logic [WORD_W-1:0] word;
        format_e fmt;
        logic [VAR_W-1:0] row;
    } fetch_s;

    typedef struct packed {
        operand_e kind;
        logic [REG_W-1:0] num;
    } operand_s;

    typedef struct packed {
        logic valid;
        logic illegal;
        format_e fmt;
        operand_s src;
        operand_s src2;
        operand_s dst;
        logic [3:0] disp_bits;
        logic [DISP_W-1:0] disp;
        logic [IMM_W-1:0] imm;
    } decode_s;

endpackage

// File: hw/operand_format_decoder.sv
/*
 * Operand format decoder for 16-bit instruction words. Takes a word with its
 * format and row from the fetch side and, one clock later, presents register
 * numbers, displacement, immediate and operand meanings to the execute stage.
 * Assumes the execute stage accepts one result every cycle; there is no stall.
 */
// Operation
// - Register-pair words give the destination from bits 11..8 and the source from 7..4.
// - Source-displacement words give the base register from bits 7..4 and a 4-bit offset.
// - Short store words give the base from bits 7..4, a 4-bit offset, register zero as source.
// - Three-field words give two registers from 11..8 and 7..4 and a 4-bit offset.
// - Byte-offset words use the low byte relative to the global base or the program counter.
// - Long branch words use the low twelve bits as a program-counter-relative offset.
// - Register-load words give the destination from 11..8 and a PC-relative low byte.
// - Immediate words give the low byte to register zero, global base memory or a trap.
// - Register-immediate words give the destination from 11..8 and the low byte as data.
// - Single-source words can name a register holding a far branch offset from the PC.
// - Multiply-accumulate uses both fields as post-increment sources into the accumulator.
// - Single-source words allow a post-increment load into a control or system register.
`timescale 1ns/100ps

module operand_format_decoder
    import operand_decode_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire fetch_s fetch,
    output decode_s decoded
);

    // ****************************************************************
    // Reset release
    // ****************************************************************
    logic [1:0] rst_sync_q;
    logic rst_n_sync;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_q <= RST_SYNC_CLEAR;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n_sync = rst_sync_q[1];

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [REG_W-1:0] nib(input logic [WORD_W-1:0] w, input int lsb);
        logic [WORD_W-1:0] sh;
        sh = w >> lsb;
        return sh[REG_W-1:0];
    endfunction

    function automatic operand_s opnd(input operand_e kind, input logic [REG_W-1:0] num);
        operand_s o;
        o.kind = kind;
        o.num = num;
        return o;
    endfunction

    // Displacements leave here zero-extended; scaling and sign extension
    // belong to the address stage, which knows the access size.
    function automatic decode_s decode_word(input fetch_s f);
        decode_s r;
        logic [REG_W-1:0] hi;
        logic [REG_W-1:0] mid;
        logic [REG_W-1:0] lo;
        logic [WORD_W-1:0] sh;
        logic [IMM_W-1:0] low_byte;
        r = '0;
        hi = nib(f.word, HI_NIB_LSB);
        mid = nib(f.word, MID_NIB_LSB);
        lo = nib(f.word, LO_NIB_LSB);
        sh = f.word >> BYTE_LSB;
        low_byte = sh[IMM_W-1:0];
        r.valid = f.valid;
        r.fmt = f.fmt;
        case (f.fmt)
            FMT_ZERO: begin
                r.illegal = (f.row != ROW_0);
            end
            FMT_N: begin
                r.dst = opnd(OPD_DIRECT, hi);
                case (f.row)
                    ROW_0: ;
                    ROW_1: r.src = opnd(OPD_CTRL_SYS, REG_ZERO);
                    ROW_2: begin
                        r.src = opnd(OPD_CTRL_SYS, REG_ZERO);
                        r.dst = opnd(OPD_PRE_DEC, hi);
                    end
                    default: r.illegal = 1'b1;
                endcase
            end
            FMT_M: begin
                case (f.row)
                    ROW_0: begin
                        r.src = opnd(OPD_DIRECT, hi);
                        r.dst = opnd(OPD_CTRL_SYS, REG_ZERO);
                    end
                    ROW_1: begin
                        r.src = opnd(OPD_POST_INC, hi);
                        r.dst = opnd(OPD_CTRL_SYS, REG_ZERO);
                    end
                    ROW_2: r.src = opnd(OPD_INDIRECT, hi);
                    ROW_3: r.src = opnd(OPD_PC_REL_REG, hi);
                    default: r.illegal = 1'b1;
                endcase
            end
            FMT_NM: begin
                r.src = opnd(OPD_DIRECT, mid);
                r.dst = opnd(OPD_DIRECT, hi);
                case (f.row)
                    ROW_0: ;
                    ROW_1: r.dst = opnd(OPD_INDIRECT, hi);
                    ROW_2: begin
                        r.src = opnd(OPD_POST_INC, mid);
                        r.src2 = opnd(OPD_POST_INC, hi);
                        r.dst = opnd(OPD_ACCUM, REG_ZERO);
                    end
                    ROW_3: r.src = opnd(OPD_POST_INC, mid);
                    ROW_4: r.dst = opnd(OPD_PRE_DEC, hi);
                    ROW_5: r.dst = opnd(OPD_INDEXED_ZERO, hi);
                    default: r.illegal = 1'b1;
                endcase
            end
            FMT_MD: begin
                r.src = opnd(OPD_REG_DISP, mid);
                r.dst = opnd(OPD_DIRECT, REG_ZERO);
                r.disp_bits = DISP_BITS_4;
                r.disp = DISP_W'(lo);
                r.illegal = (f.row != ROW_0);
            end
            FMT_ND4: begin
                r.src = opnd(OPD_DIRECT, REG_ZERO);
                r.dst = opnd(OPD_REG_DISP, mid);
                r.disp_bits = DISP_BITS_4;
                r.disp = DISP_W'(lo);
                r.illegal = (f.row != ROW_0);
            end
            FMT_NMD: begin
                r.disp_bits = DISP_BITS_4;
                r.disp = DISP_W'(lo);
                case (f.row)
                    ROW_0: begin
                        r.src = opnd(OPD_DIRECT, mid);
                        r.dst = opnd(OPD_REG_DISP, hi);
                    end
                    ROW_1: begin
                        r.src = opnd(OPD_REG_DISP, mid);
                        r.dst = opnd(OPD_DIRECT, hi);
                    end
                    default: r.illegal = 1'b1;
                endcase
            end
            FMT_D: begin
                r.disp_bits = DISP_BITS_8;
                r.disp = DISP_W'(low_byte);
                case (f.row)
                    ROW_0: begin
                        r.src = opnd(OPD_GBASE_DISP, REG_ZERO);
                        r.dst = opnd(OPD_DIRECT, REG_ZERO);
                    end
                    ROW_1: begin
                        r.src = opnd(OPD_DIRECT, REG_ZERO);
                        r.dst = opnd(OPD_GBASE_DISP, REG_ZERO);
                    end
                    ROW_2: begin
                        r.src = opnd(OPD_PC_DISP, REG_ZERO);
                        r.dst = opnd(OPD_DIRECT, REG_ZERO);
                    end
                    ROW_3: r.src = opnd(OPD_PC_REL, REG_ZERO);
                    default: r.illegal = 1'b1;
                endcase
            end
            FMT_D12: begin
                r.src = opnd(OPD_PC_REL, REG_ZERO);
                r.disp_bits = DISP_BITS_12;
                r.disp = sh[DISP_W-1:0] >> D12_LSB;
                r.illegal = (f.row != ROW_0);
            end
            FMT_ND8: begin
                r.src = opnd(OPD_PC_DISP, REG_ZERO);
                r.dst = opnd(OPD_DIRECT, hi);
                r.disp_bits = DISP_BITS_8;
                r.disp = DISP_W'(low_byte);
                r.illegal = (f.row != ROW_0);
            end
            FMT_I: begin
                r.src = opnd(OPD_IMMEDIATE, REG_ZERO);
                r.imm = low_byte;
                case (f.row)
                    ROW_0: r.dst = opnd(OPD_GBASE_INDEXED, REG_ZERO);
                    ROW_1: r.dst = opnd(OPD_DIRECT, REG_ZERO);
                    ROW_2: r.src = opnd(OPD_TRAP, REG_ZERO);
                    default: r.illegal = 1'b1;
                endcase
            end
            FMT_NI: begin
                r.src = opnd(OPD_IMMEDIATE, REG_ZERO);
                r.dst = opnd(OPD_DIRECT, hi);
                r.imm = low_byte;
                r.illegal = (f.row != ROW_0);
            end
            default: r.illegal = 1'b1;
        endcase
        return r;
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    // Fields hold their last value while no word is offered, so the execute
    // stage may sample them late; only valid drops.
    decode_s state_q;
    decode_s state_d;

    always_comb begin
        state_d = state_q;
        state_d.valid = 1'b0;
        if (fetch.valid) begin
            state_d = decode_word(fetch);
        end
    end

    always_ff @(posedge clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign decoded = state_q;

endmodule // operand_format_decoder

// File: sim/operand_decoder_props.sv
/* Port checker for the operand format decoder.
 * Assumes it is bound to the decoder top and sees only its ports. */
`timescale 1ns/100ps
module operand_decoder_props
    import operand_decode_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire fetch_s fetch,
    input wire decode_s decoded
);
    // ****************************************
    // Word taken one edge ago, tied to each result.
    // ****************************************
    fetch_s fetch_q;
    logic tk;
    logic [3:0] hi;
    logic [3:0] mid;
    logic [3:0] lo;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fetch_q <= '0;
        end else begin
            fetch_q <= fetch;
        end
    end
    assign tk = fetch_q.valid && fetch_q.row == ROW_0;
    assign hi = fetch_q.word[11:8];
    assign mid = fetch_q.word[7:4];
    assign lo = fetch_q.word[3:0];
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_take; fetch.valid |=> decoded.valid; endproperty
    a_take: assert property (p_take) else $error("no result after a word");
    property p_idle; !fetch.valid |=> !decoded.valid && $stable(decoded.disp); endproperty
    a_idle: assert property (p_idle) else $error("result moved while idle");
    property p_fmt; fetch_q.valid |-> decoded.fmt == fetch_q.fmt; endproperty
    a_fmt: assert property (p_fmt) else $error("format code wrong");
    property p_pair;
        tk && fetch_q.fmt == FMT_NM |-> decoded.src.num == mid && decoded.dst.num == hi;
    endproperty
    a_pair: assert property (p_pair) else $error("register pair wrong");
    property p_sdisp;
        tk && fetch_q.fmt == FMT_MD |-> decoded.src.num == mid && decoded.disp == {8'h00, lo};
    endproperty
    a_sdisp: assert property (p_sdisp) else $error("source offset wrong");
    property p_store;
        tk && fetch_q.fmt == FMT_ND4 |-> decoded.dst.num == mid && decoded.src.num == REG_ZERO;
    endproperty
    a_store: assert property (p_store) else $error("short store wrong");
    property p_three;
        fetch_q.valid && fetch_q.fmt == FMT_NMD |-> decoded.disp == {8'h00, lo};
    endproperty
    a_three: assert property (p_three) else $error("three field offset wrong");
    property p_byte;
        tk && fetch_q.fmt == FMT_D |-> decoded.disp == {4'h0, fetch_q.word[7:0]};
    endproperty
    a_byte: assert property (p_byte) else $error("byte offset wrong");
    property p_long;
        tk && fetch_q.fmt == FMT_D12 |-> decoded.disp == fetch_q.word[11:0];
    endproperty
    a_long: assert property (p_long) else $error("long branch offset wrong");
    property p_imm;
        tk && fetch_q.fmt == FMT_NI |-> decoded.imm == fetch_q.word[7:0] && decoded.dst.num == hi;
    endproperty
    a_imm: assert property (p_imm) else $error("register immediate wrong");
endmodule // operand_decoder_props

bind operand_format_decoder operand_decoder_props props_u (
    .clk(clk), .nrst(nrst), .fetch(fetch), .decoded(decoded));

// File: sim/exec_sink.sv
/* Execute-side stand-in that counts decoded results.
 * Assumes results arrive at most one a cycle and are never stalled. */
`timescale 1ns/100ps
module exec_sink
    import operand_decode_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire decode_s decoded,
    output int taken
);
    // The real stage cannot push back, so this one never does either.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            taken <= 0;
        end else if (decoded.valid) begin
            taken <= taken + 1;
        end
    end
endmodule // exec_sink

// File: sim/cpu_operand_format_decoder_tb.sv
/* Self-checking bench for the operand format decoder.
 * Assumes the decoder answers one clock after each taken word. */
`timescale 1ns/100ps
module cpu_operand_format_decoder_tb
    import operand_decode_pkg::*;
;
    localparam logic [15:0] W = 16'h5A3C;
    localparam operand_s N0 = '{OPD_NONE, 4'h0};
    logic clk;
    logic nrst;
    fetch_s fetch;
    decode_s decoded;
    int taken;
    int sent;
    int err_count;
    int num_checks;
    operand_format_decoder dut_u (.clk(clk), .nrst(nrst), .fetch(fetch), .decoded(decoded));
    exec_sink sink_u (.clk(clk), .nrst(nrst), .decoded(decoded), .taken(taken));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ****************************************
    // Shared drivers and comparisons
    // ****************************************
    function automatic operand_s o(input operand_e k, input logic [3:0] n);
        return '{k, n};
    endfunction
    task automatic ck(input string n, input logic [15:0] e, input logic [15:0] s);
        num_checks++;
        if (s !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic cmp(input decode_s e);
        num_checks++;
        if (decoded !== e) begin
            err_count++;
            $display("wrong value decoded expected %h seen %h", e, decoded);
        end
    endtask
    task automatic x(format_e f, logic [2:0] r, operand_s s, operand_s s2, operand_s d,
        logic [3:0] db, logic [11:0] dp, logic [7:0] im);
        @(posedge clk) fetch <= '{1'b1, W, f, r};
        @(posedge clk) fetch.valid <= 1'b0;
        #1 cmp('{1'b1, 1'b0, f, s, s2, d, db, dp, im});
        sent++;
    endtask
    task automatic xr(format_e f, logic [2:0] r, operand_s s, operand_s s2, operand_s d);
        x(f, r, s, s2, d, DISP_BITS_NONE, 12'h000, 8'h00);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_pair();
        xr(FMT_NM, ROW_0, o(OPD_DIRECT, 4'h3), N0, o(OPD_DIRECT, 4'hA));
        xr(FMT_NM, ROW_1, o(OPD_DIRECT, 4'h3), N0, o(OPD_INDIRECT, 4'hA));
        xr(FMT_NM, ROW_2, o(OPD_POST_INC, 4'h3), o(OPD_POST_INC, 4'hA),
            o(OPD_ACCUM, 4'h0));
        xr(FMT_NM, ROW_3, o(OPD_POST_INC, 4'h3), N0, o(OPD_DIRECT, 4'hA));
        xr(FMT_NM, ROW_4, o(OPD_DIRECT, 4'h3), N0, o(OPD_PRE_DEC, 4'hA));
        xr(FMT_NM, ROW_5, o(OPD_DIRECT, 4'h3), N0, o(OPD_INDEXED_ZERO, 4'hA));
        $display("test pair done");
    endtask
    task automatic t_single();
        xr(FMT_ZERO, ROW_0, N0, N0, N0);
        xr(FMT_N, ROW_0, N0, N0, o(OPD_DIRECT, 4'hA));
        xr(FMT_N, ROW_1, o(OPD_CTRL_SYS, 4'h0), N0, o(OPD_DIRECT, 4'hA));
        xr(FMT_N, ROW_2, o(OPD_CTRL_SYS, 4'h0), N0, o(OPD_PRE_DEC, 4'hA));
        xr(FMT_M, ROW_0, o(OPD_DIRECT, 4'hA), N0, o(OPD_CTRL_SYS, 4'h0));
        xr(FMT_M, ROW_1, o(OPD_POST_INC, 4'hA), N0, o(OPD_CTRL_SYS, 4'h0));
        xr(FMT_M, ROW_2, o(OPD_INDIRECT, 4'hA), N0, N0);
        xr(FMT_M, ROW_3, o(OPD_PC_REL_REG, 4'hA), N0, N0);
        $display("test single done");
    endtask
    task automatic t_disp();
        x(FMT_MD, ROW_0, o(OPD_REG_DISP, 4'h3), N0, o(OPD_DIRECT, 4'h0),
            DISP_BITS_4, 12'h00C, 8'h00);
        x(FMT_ND4, ROW_0, o(OPD_DIRECT, 4'h0), N0, o(OPD_REG_DISP, 4'h3),
            DISP_BITS_4, 12'h00C, 8'h00);
        x(FMT_NMD, ROW_0, o(OPD_DIRECT, 4'h3), N0, o(OPD_REG_DISP, 4'hA),
            DISP_BITS_4, 12'h00C, 8'h00);
        x(FMT_NMD, ROW_1, o(OPD_REG_DISP, 4'h3), N0, o(OPD_DIRECT, 4'hA),
            DISP_BITS_4, 12'h00C, 8'h00);
        x(FMT_D12, ROW_0, o(OPD_PC_REL, 4'h0), N0, N0, DISP_BITS_12, 12'hA3C, 8'h00);
        x(FMT_ND8, ROW_0, o(OPD_PC_DISP, 4'h0), N0, o(OPD_DIRECT, 4'hA),
            DISP_BITS_8, 12'h03C, 8'h00);
        $display("test disp done");
    endtask
    task automatic t_byte();
        x(FMT_D, ROW_0, o(OPD_GBASE_DISP, 4'h0), N0, o(OPD_DIRECT, 4'h0),
            DISP_BITS_8, 12'h03C, 8'h00);
        x(FMT_D, ROW_1, o(OPD_DIRECT, 4'h0), N0, o(OPD_GBASE_DISP, 4'h0),
            DISP_BITS_8, 12'h03C, 8'h00);
        x(FMT_D, ROW_2, o(OPD_PC_DISP, 4'h0), N0, o(OPD_DIRECT, 4'h0),
            DISP_BITS_8, 12'h03C, 8'h00);
        x(FMT_D, ROW_3, o(OPD_PC_REL, 4'h0), N0, N0, DISP_BITS_8, 12'h03C, 8'h00);
        x(FMT_I, ROW_0, o(OPD_IMMEDIATE, 4'h0), N0, o(OPD_GBASE_INDEXED, 4'h0),
            4'h0, 12'h000, 8'h3C);
        x(FMT_I, ROW_1, o(OPD_IMMEDIATE, 4'h0), N0, o(OPD_DIRECT, 4'h0),
            4'h0, 12'h000, 8'h3C);
        x(FMT_I, ROW_2, o(OPD_TRAP, 4'h0), N0, N0, 4'h0, 12'h000, 8'h3C);
        x(FMT_NI, ROW_0, o(OPD_IMMEDIATE, 4'h0), N0, o(OPD_DIRECT, 4'hA),
            4'h0, 12'h000, 8'h3C);
        $display("test byte done");
    endtask
    task automatic t_stream();
        @(posedge clk) fetch <= '{1'b1, 16'h2356, FMT_NM, ROW_0};
        @(posedge clk) fetch <= '{1'b1, W, FMT_D12, ROW_1};
        #1 cmp('{1'b1, 1'b0, FMT_NM, o(OPD_DIRECT, 4'h5), N0, o(OPD_DIRECT, 4'h3),
            4'h0, 12'h000, 8'h00});
        @(posedge clk) fetch.valid <= 1'b0;
        #1 ck("illegal", 16'h0003, {14'h0, decoded.valid, decoded.illegal});
        @(posedge clk) #1 ck("held", {12'h000, FMT_D12},
            {11'h000, decoded.valid, decoded.fmt});
        @(posedge clk) fetch <= '{1'b1, W, FMT_N, 3'h7};
        @(posedge clk) fetch.valid <= 1'b0;
        #1 ck("bad row", 16'h0003, {14'h0, decoded.valid, decoded.illegal});
        sent += 3;
        $display("test stream done");
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (2000) @(posedge clk);
        err_count++;
        finish_test();
    end
    initial begin
        err_count = 0;
        num_checks = 0;
        sent = 0;
        nrst = 1'b0;
        fetch = '0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        t_pair();
        t_single();
        t_disp();
        t_byte();
        t_stream();
        repeat (2) @(posedge clk);
        #1 ck("taken", 16'(sent), 16'(taken));
        finish_test();
    end
endmodule // cpu_operand_format_decoder_tb
